/* File: hw/asg_pkg.sv */
package asg_pkg;

	localparam int unsigned CLK_FREQ_HZ = 200_000_000;

	// Register page offsets and field layout
	localparam logic [7:0] ADDR_LOOP_FIRST  = 8'h1b;
	localparam logic [7:0] ADDR_LOOP_SECOND = 8'h1c;
	localparam int unsigned J_LSB     = 0;
	localparam int unsigned J_W       = 7;
	localparam int unsigned P_LSB     = 8;
	localparam int unsigned P_W       = 3;
	localparam int unsigned STAT_BIT  = 15;
	localparam int unsigned D_LSB     = 0;
	localparam int unsigned D_W       = 14;

	// Reset values of the loop factors
	localparam logic [J_W-1:0] J_RESET = 7'h08;
	localparam logic [P_W-1:0] P_RESET = 3'h1;
	localparam logic [D_W-1:0] D_RESET = 14'h0780;

	// Factor limits
	localparam logic [J_W-1:0] J_MIN = 7'h01;
	localparam logic [J_W-1:0] J_MAX = 7'h40;
	localparam logic [D_W-1:0] D_MAX = 14'h270f;
	localparam logic [4:0]     Q_MIN = 5'h02;
	localparam logic [4:0]     Q_MAX = 5'h11;

	// Rate arithmetic constants
	localparam int unsigned BYPASS_SCALE = 128;
	localparam int unsigned LOOP_SCALE   = 2048;
	localparam int unsigned FRAC_SCALE   = 10000;
	localparam int unsigned ACC_W        = 29;
	localparam int unsigned BYP_W        = 12;

	typedef struct packed {
		logic [J_W-1:0] j;
		logic [P_W-1:0] p;
		logic [D_W-1:0] d;
	} asg_loop_factors_t;

	// Divisor select codes 0..7 map to 1, 1.5, 2, 3, 4, 5, 5.5, 6
	typedef logic [2:0] asg_div_sel_t;

	function automatic logic [4:0] asg_half_units(input asg_div_sel_t sel);
		logic [4:0] r;
		r = 5'h02;
		case (sel)
			3'h0: r = 5'h02;
			3'h1: r = 5'h03;
			3'h2: r = 5'h04;
			3'h3: r = 5'h06;
			3'h4: r = 5'h08;
			3'h5: r = 5'h0a;
			3'h6: r = 5'h0b;
			3'h7: r = 5'h0c;
			default: r = 5'h02;
		endcase
		return r;
	endfunction

endpackage

/* File: hw/asg_rate_div.sv */
`timescale 1ns/1ps
module asg_rate_div
	import asg_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ref_stb,
	input  wire logic [4:0] i_half_units,
	output logic            o_wclk,
	output logic            o_stb
);
	// Accumulator in quarter-sample units: each reference strobe adds four,
	// each word clock half period costs half_units; remainder carries over
	logic [5:0] acc_ff;
	logic [5:0] nxt_acc;
	logic       wclk_ff;
	logic       stb_ff;
	logic       toggle;

	always_comb
	begin
		toggle  = (acc_ff >= {1'b0, i_half_units});
		nxt_acc = acc_ff;
		if (toggle)
			nxt_acc = acc_ff - {1'b0, i_half_units};
		if (i_ref_stb)
			nxt_acc = nxt_acc + 6'h04;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			acc_ff <= 6'h00;
		else
			acc_ff <= nxt_acc;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wclk_ff <= 1'b0;
			stb_ff  <= 1'b0;
		end
		else
		begin
			if (toggle)
				wclk_ff <= ~wclk_ff;
			stb_ff <= toggle & ~wclk_ff;
		end
	end

	assign o_wclk = wclk_ff;
	assign o_stb  = stb_ff;
endmodule

/* File: hw/asg_clock_gen.sv */
// Functional notes
// - Master clock of 2 to 100 MHz drives all converter clock derivation; CLK_FREQ_HZ here is 200 MHz.
// - Playback and record rates are reference over their own divisor choices.
// - A control input selects bypass divider or fractional multiplier loop.
// - Loop off: reference is master clock over 128 times Q, Q 2..17.
// - Loop on: reference is master times ratio over 2048 times P (1..8).
// - Fraction held as four decimal digits 0..9999; one half is 5000.
// - Loop factors live in registers at offsets 1B and 1C.
// - One bit tells which reference family, 44.1 or 48 kHz, is used.
// - Equal rates share one word clock; else record uses its own pin.
`timescale 1ns/1ps
module asg_clock_gen
	import asg_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_reset_n,
	input  wire logic                i_loop_enable,
	input  wire logic [4:0]          i_bypass_q,
	input  wire asg_pkg::asg_div_sel_t i_playback_rate_divisor,
	input  wire asg_pkg::asg_div_sel_t i_record_rate_divisor,
	input  wire logic                i_family_48k,
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	input  wire logic [7:0]          i_reg_addr,
	input  wire logic [15:0]         i_reg_wdata,
	output logic [15:0]              o_reg_rdata,
	output logic                     o_reg_rvalid,
	output logic                     o_fsref_stb,
	output logic                     o_play_stb,
	output logic                     o_rec_stb,
	output logic                     o_word_clk,
	output logic                     o_record_word_clock_pin,
	output logic                     o_family_48k
);
	import asg_pkg::*;

	logic                  rst_meta_ff;
	logic                  rst_sync_ff;
	asg_loop_factors_t     fac_ff;
	logic [15:0]           rdata_ff;
	logic                  rvalid_ff;
	logic [ACC_W-1:0]      nco_ff;
	logic [ACC_W-1:0]      nxt_nco;
	logic [BYP_W-1:0]      byp_cnt_ff;
	logic [BYP_W-1:0]      byp_limit;
	logic [ACC_W-1:0]      nco_inc;
	logic [ACC_W-1:0]      nco_thr;
	logic [3:0]            p_val;
	logic [4:0]            q_val;
	logic                  ref_stb;
	logic                  ref_stb_ff;
	logic                  play_wclk;
	logic                  rec_wclk;
	logic                  play_stb;
	logic                  rec_stb;
	logic                  play_stb_ff;
	logic                  rec_stb_ff;
	logic                  wclk_ff;
	logic                  rec_pin_ff;
	logic                  family_ff;
	logic [J_W-1:0]        wr_j;
	logic [D_W-1:0]        wr_d;

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Out-of-range factors are clamped on write
	always_comb
	begin
		wr_j = i_reg_wdata[J_LSB +: J_W];
		if (wr_j < J_MIN)
			wr_j = J_MIN;
		else if (wr_j > J_MAX)
			wr_j = J_MAX;
		wr_d = i_reg_wdata[D_LSB +: D_W];
		if (wr_d > D_MAX)
			wr_d = D_MAX;
	end

	always_ff @(posedge i_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			fac_ff.j <= J_RESET;
			fac_ff.p <= P_RESET;
			fac_ff.d <= D_RESET;
		end
		else if (i_reg_wr)
		begin
			if (i_reg_addr == ADDR_LOOP_FIRST)
			begin
				fac_ff.j <= wr_j;
				fac_ff.p <= i_reg_wdata[P_LSB +: P_W];
			end
			else if (i_reg_addr == ADDR_LOOP_SECOND)
				fac_ff.d <= wr_d;
		end
	end

	// Readback; bit 15 of the first register shows whether the loop is in use
	always_ff @(posedge i_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			rdata_ff  <= 16'h0000;
			rvalid_ff <= 1'b0;
		end
		else
		begin
			rvalid_ff <= i_reg_rd;
			if (i_reg_rd)
			begin
				rdata_ff <= 16'h0000;
				if (i_reg_addr == ADDR_LOOP_FIRST)
				begin
					rdata_ff[J_LSB +: J_W] <= fac_ff.j;
					rdata_ff[P_LSB +: P_W] <= fac_ff.p;
					rdata_ff[STAT_BIT]     <= i_loop_enable;
				end
				else if (i_reg_addr == ADDR_LOOP_SECOND)
					rdata_ff[D_LSB +: D_W] <= fac_ff.d;
			end
		end
	end

	// P field value 0 encodes 8; Q is clamped into 2..17
	always_comb
	begin
		p_val = (fac_ff.p == 3'h0) ? 4'h8 : {1'b0, fac_ff.p};
		q_val = i_bypass_q;
		if (q_val < Q_MIN)
			q_val = Q_MIN;
		else if (q_val > Q_MAX)
			q_val = Q_MAX;
		byp_limit = BYP_W'(BYPASS_SCALE) * {{(BYP_W-5){1'b0}}, q_val};
		nco_inc   = ACC_W'(fac_ff.j) * ACC_W'(FRAC_SCALE) + ACC_W'(fac_ff.d);
		nco_thr   = ACC_W'(LOOP_SCALE) * ACC_W'(FRAC_SCALE) * ACC_W'(p_val);
	end

	// Loop mode: every master cycle adds K*10000; each wrap is one reference sample
	always_comb
	begin
		nxt_nco = nco_ff + nco_inc;
		ref_stb = 1'b0;
		if (i_loop_enable)
		begin
			if (nxt_nco >= nco_thr)
			begin
				nxt_nco = nxt_nco - nco_thr;
				ref_stb = 1'b1;
			end
		end
		else
		begin
			nxt_nco = '0;
			ref_stb = (byp_cnt_ff >= byp_limit - 12'h001);
		end
	end

	always_ff @(posedge i_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			nco_ff <= '0;
		else
			nco_ff <= nxt_nco;
	end

	always_ff @(posedge i_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
			byp_cnt_ff <= '0;
		else if (i_loop_enable || ref_stb)
			byp_cnt_ff <= '0;
		else
			byp_cnt_ff <= byp_cnt_ff + 12'h001;
	end

	asg_rate_div u_play_div (
		.i_clk        (i_clk),
		.i_rst_n      (rst_sync_ff),
		.i_ref_stb    (ref_stb),
		.i_half_units (asg_half_units(i_playback_rate_divisor)),
		.o_wclk       (play_wclk),
		.o_stb        (play_stb)
	);

	asg_rate_div u_rec_div (
		.i_clk        (i_clk),
		.i_rst_n      (rst_sync_ff),
		.i_ref_stb    (ref_stb),
		.i_half_units (asg_half_units(i_record_rate_divisor)),
		.o_wclk       (rec_wclk),
		.o_stb        (rec_stb)
	);

	// Record pin carries its own word clock only when the two rates differ
	always_ff @(posedge i_clk or negedge rst_sync_ff)
	begin
		if (!rst_sync_ff)
		begin
			ref_stb_ff  <= 1'b0;
			play_stb_ff <= 1'b0;
			rec_stb_ff  <= 1'b0;
			wclk_ff     <= 1'b0;
			rec_pin_ff  <= 1'b0;
			family_ff   <= 1'b0;
		end
		else
		begin
			ref_stb_ff  <= ref_stb;
			play_stb_ff <= play_stb;
			rec_stb_ff  <= rec_stb;
			wclk_ff     <= play_wclk;
			rec_pin_ff  <= (i_playback_rate_divisor != i_record_rate_divisor) & rec_wclk;
			family_ff   <= i_family_48k;
		end
	end

	assign o_reg_rdata             = rdata_ff;
	assign o_reg_rvalid            = rvalid_ff;
	assign o_fsref_stb             = ref_stb_ff;
	assign o_play_stb              = play_stb_ff;
	assign o_rec_stb               = rec_stb_ff;
	assign o_word_clk              = wclk_ff;
	assign o_record_word_clock_pin = rec_pin_ff;
	assign o_family_48k            = family_ff;
endmodule

/* File: bench/asg_host.sv */
`timescale 1ns/1ps
module asg_host
(
	input  wire logic        i_clk,
	input  wire logic [15:0] i_rdata,
	input  wire logic        i_rvalid,
	output logic             o_wr = 1'b0,
	output logic             o_rd = 1'b0,
	output logic [7:0]       o_addr = 8'h00,
	output logic [15:0]      o_wdata = 16'h0000
);
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask

	// Data is taken at the edge where the answer is seen
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		do
			@(posedge i_clk);
		while (i_rvalid !== 1'b1);
		d = i_rdata;
	endtask
endmodule

/* File: bench/asg_clock_gen_props.sv */
`timescale 1ns/1ps
module asg_clock_gen_props
	import asg_pkg::*;
(
	input wire logic         i_clk,
	input wire logic         i_reset_n,
	input wire logic         i_loop_enable,
	input wire asg_div_sel_t i_playback_rate_divisor,
	input wire asg_div_sel_t i_record_rate_divisor,
	input wire logic         i_family_48k,
	input wire logic         i_reg_rd,
	input wire logic [7:0]   i_reg_addr,
	input wire logic [15:0]  o_reg_rdata,
	input wire logic         o_reg_rvalid,
	input wire logic         o_fsref_stb,
	input wire logic         o_play_stb,
	input wire logic         o_record_word_clock_pin,
	input wire logic         o_family_48k
);
	logic [1:0] rel_cnt_ff;
	logic       ok;

	// Skips the cycles while the internal reset copy is still low
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rel_cnt_ff <= 2'h0;
		else if (rel_cnt_ff != 2'h3)
			rel_cnt_ff <= rel_cnt_ff + 2'h1;
	end
	assign ok = (rel_cnt_ff == 2'h3);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	a_rvalid_after_rd: assert property (ok && i_reg_rd |=> o_reg_rvalid)
		else $error("read not answered");
	a_rvalid_has_cause: assert property (ok && o_reg_rvalid |-> $past(i_reg_rd))
		else $error("answer without read");
	a_unmapped_zero: assert property (ok && i_reg_rd && i_reg_addr != ADDR_LOOP_FIRST
		&& i_reg_addr != ADDR_LOOP_SECOND |=> o_reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_loop_bit_read: assert property (ok && i_reg_rd && i_reg_addr == ADDR_LOOP_FIRST
		|=> o_reg_rdata[15] == $past(i_loop_enable))
		else $error("loop bit wrong");
	a_family_follow: assert property (ok |=> o_family_48k == $past(i_family_48k))
		else $error("family flag lags");
	a_fsref_pulse: assert property (o_fsref_stb |=> !o_fsref_stb)
		else $error("reference strobe too long");
	a_play_pulse: assert property (o_play_stb |=> !o_play_stb)
		else $error("playback strobe too long");
	a_pin_shared: assert property ((i_playback_rate_divisor == i_record_rate_divisor) [*4]
		|-> !o_record_word_clock_pin)
		else $error("record pin active with shared clock");
endmodule

bind asg_clock_gen asg_clock_gen_props u_props (
	.i_clk                   (i_clk),
	.i_reset_n               (i_reset_n),
	.i_loop_enable           (i_loop_enable),
	.i_playback_rate_divisor (i_playback_rate_divisor),
	.i_record_rate_divisor   (i_record_rate_divisor),
	.i_family_48k            (i_family_48k),
	.i_reg_rd                (i_reg_rd),
	.i_reg_addr              (i_reg_addr),
	.o_reg_rdata             (o_reg_rdata),
	.o_reg_rvalid            (o_reg_rvalid),
	.o_fsref_stb             (o_fsref_stb),
	.o_play_stb              (o_play_stb),
	.o_record_word_clock_pin (o_record_word_clock_pin),
	.o_family_48k            (o_family_48k)
);

/* File: bench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
	import asg_pkg::*;
	logic         i_clk = 1'b0, i_reset_n = 1'b0, i_loop_enable = 1'b0, i_family_48k = 1'b0;
	logic [4:0]   i_bypass_q = 5'h02;
	asg_div_sel_t i_playback_rate_divisor = 3'h0, i_record_rate_divisor = 3'h0;
	logic         i_reg_wr, i_reg_rd, o_reg_rvalid, o_fsref_stb, o_play_stb, o_rec_stb;
	logic         o_word_clk, o_record_word_clock_pin, o_family_48k;
	logic [7:0]   i_reg_addr;
	logic [15:0]  i_reg_wdata, o_reg_rdata, rdat;
	int           mismatches = 0, checks_done = 0, n;

	always #2.5 i_clk = ~i_clk;
	asg_clock_gen u_asg_clock_gen (
		.i_clk                   (i_clk),
		.i_reset_n               (i_reset_n),
		.i_loop_enable           (i_loop_enable),
		.i_bypass_q              (i_bypass_q),
		.i_playback_rate_divisor (i_playback_rate_divisor),
		.i_record_rate_divisor   (i_record_rate_divisor),
		.i_family_48k            (i_family_48k),
		.i_reg_wr                (i_reg_wr),
		.i_reg_rd                (i_reg_rd),
		.i_reg_addr              (i_reg_addr),
		.i_reg_wdata             (i_reg_wdata),
		.o_reg_rdata             (o_reg_rdata),
		.o_reg_rvalid            (o_reg_rvalid),
		.o_fsref_stb             (o_fsref_stb),
		.o_play_stb              (o_play_stb),
		.o_rec_stb               (o_rec_stb),
		.o_word_clk              (o_word_clk),
		.o_record_word_clock_pin (o_record_word_clock_pin),
		.o_family_48k            (o_family_48k)
	);
	asg_host u_asg_host (.i_clk(i_clk), .i_rdata(o_reg_rdata), .i_rvalid(o_reg_rvalid),
		.o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));

	function automatic logic pick(input int k);
		return (k == 0) ? o_fsref_stb : (k == 1) ? o_play_stb : o_rec_stb;
	endfunction

	// Two strobes to settle after a change, then the sum of cnt gaps
	task automatic rate(input int k, input int cnt, input int exp);
		n = 0;
		repeat (2) do @(posedge i_clk); while (pick(k) !== 1'b1);
		repeat (cnt) do begin @(posedge i_clk); n++; end while (pick(k) !== 1'b1);
		`CHK(n, exp)
		// A sample strobe marks the rising edge of its word clock
		if (k == 1)
			`CHK(o_word_clk, 1'b1)
		else if (k == 2)
			`CHK(o_record_word_clock_pin, 1'b1)
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
		u_asg_host.rd(a, rdat);
		`CHK(rdat, e)
	endtask

	task automatic close_out;
		if (mismatches == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		repeat (20) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk_rd(ADDR_LOOP_FIRST, 16'h0108);
		chk_rd(ADDR_LOOP_SECOND, 16'h0780);
		u_asg_host.wr(8'h1d, 16'hffff);
		chk_rd(8'h1d, 16'h0000);
		rate(0, 1, 256);
		i_playback_rate_divisor <= 3'h7;
		i_record_rate_divisor <= 3'h1;
		i_family_48k <= 1'b1;
		rate(1, 1, 1536);
		`CHK(o_family_48k, 1'b1)
		rate(2, 2, 768);
		i_record_rate_divisor <= 3'h6;
		rate(2, 2, 2816);
		i_record_rate_divisor <= 3'h0; // Odd bypass divisor only with whole steps
		i_bypass_q <= 5'h11;
		rate(0, 1, 2176);
		i_loop_enable <= 1'b1;
		u_asg_host.wr(ADDR_LOOP_SECOND, 16'h1388);
		chk_rd(ADDR_LOOP_FIRST, 16'h8108);
		chk_rd(ADDR_LOOP_SECOND, 16'h1388);
		rate(0, 17, 4096);
		u_asg_host.wr(ADDR_LOOP_SECOND, 16'h0000);
		u_asg_host.wr(ADDR_LOOP_FIRST, 16'h0208); // Integer part kept in range
		rate(0, 1, 512);
		u_asg_host.wr(ADDR_LOOP_FIRST, 16'h0004); // P field 0 selects 8
		chk_rd(ADDR_LOOP_FIRST, 16'h8004);
		rate(0, 1, 4096); // Reference near 48.8 kHz
		close_out();
	end

	initial
	begin
		#400000;
		mismatches++;
		close_out();
	end
endmodule
